// *** hdl/ipb_bank.sv ***
// Interrupt priority field bank behind an AXI4-Lite slave
`timescale 1ns/1ps
// Functional notes
// - Three-bit fields; all ones is level 7
// - Code one is level 1, linear between
// - Code zero disables the source entirely
// - Unimplemented bits read back as zero
// - Word A bits 14:12 hold UART error
// - Word A bits 6:4 hold TWI master
// - Word A bits 2:0 hold TWI slave
// - Word B bits 10:8 hold serial fault
// - Word B bits 6:4 hold UART transmit
module ipb_bank
    import ipb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Interrupt sources (flag and enable already combined)
    input wire logic [NUM_SRC-1:0] src_req,
    // To arbitration
    output ipb_prio_t [NUM_SRC-1:0] src_level,
    output logic [NUM_SRC-1:0] src_active
);

    ipb_axi_s q;
    ipb_axi_s d;
    logic wr_fire;
    logic [NUM_SRC-1:0] fld_wr;
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;

    // Protection attributes carry no meaning for this bank
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    assign s_axi_awready = !q.aw_held && !q.bvalid;
    assign s_axi_wready = !q.w_held && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign wr_fire = q.aw_held && q.w_held && !q.bvalid;

    // Field cells and their write decode
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_cell
        localparam int unsigned POS = SRC_POS[i];
        logic hit;
        assign hit = SRC_IN_WORD_B[i] ? (q.awaddr == OFF_WORD_B) : (q.awaddr == OFF_WORD_A);
        // Each field sits inside one byte lane, so one strobe governs it
        assign fld_wr[i] = wr_fire && hit && q.wstrb[POS/8];
        ipb_prio_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .wr_en(fld_wr[i]),
            .wr_data(q.wdata[POS +: PRIO_W]),
            .src_req(src_req[i]),
            .level(src_level[i]),
            .active(src_active[i])
        );
    end

    // Read words: fields placed at their positions, every other bit zero
    always_comb begin
        word_a = '0;
        word_b = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (SRC_IN_WORD_B[i]) begin
                word_b[SRC_POS[i] +: PRIO_W] = src_level[i];
            end else begin
                word_a[SRC_POS[i] +: PRIO_W] = src_level[i];
            end
        end
        word_a = word_a & MASK_WORD_A;
        word_b = word_b & MASK_WORD_B;
    end

    always_comb begin
        d = q;
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_held = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_held = 1'b1;
            d.wdata = s_axi_wdata[WORD_W-1:0];
            d.wstrb = s_axi_wstrb[1:0];
        end
        if (wr_fire) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (q.awaddr == OFF_WORD_A || q.awaddr == OFF_WORD_B) ? RESP_OKAY
                                                                            : RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            if (s_axi_araddr == OFF_WORD_A) begin
                d.rdata = {16'h0, word_a};
            end else if (s_axi_araddr == OFF_WORD_B) begin
                d.rdata = {16'h0, word_b};
            end else begin
                d.rdata = 32'h0;
                d.rresp = RESP_SLVERR;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= AXI_RESET;
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_rsvd_read_zero: assert property (s_axi_rvalid |->
        (s_axi_rdata[31:15] == 17'h0 && s_axi_rdata[11] == 1'b0 && s_axi_rdata[7] == 1'b0
        && s_axi_rdata[3] == 1'b0))
        else $error("unimplemented bit read as one");

    chk_word_a_layout: assert property ((s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OFF_WORD_A) |=> (s_axi_rvalid && s_axi_rdata[10:7] == 4'h0
        && s_axi_rdata[14:12] == $past(src_level[SRC_UART_D_ERROR])
        && s_axi_rdata[6:4] == $past(src_level[SRC_TWI_C_MASTER])
        && s_axi_rdata[2:0] == $past(src_level[SRC_TWI_C_SLAVE])))
        else $error("word A fields misplaced");

    chk_word_b_layout: assert property ((s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OFF_WORD_B) |=> (s_axi_rvalid
        && s_axi_rdata[10:8] == $past(src_level[SRC_SERIAL_C_FAULT])
        && s_axi_rdata[6:4] == $past(src_level[SRC_UART_D_TRANSMIT])
        && s_axi_rdata[14:12] == $past(src_level[SRC_SERIAL_C_EVENT])
        && s_axi_rdata[2:0] == $past(src_level[SRC_UART_D_RECEIVE])))
        else $error("word B fields misplaced");

    chk_write_to_level: assert property ((wr_fire && q.awaddr == OFF_WORD_A && q.wstrb[1])
        |=> s_axi_bvalid && src_level[SRC_UART_D_ERROR] == $past(q.wdata[14:12]))
        else $error("write to word A bits 14:12 not applied");

    // Bus answers: a write lands one edge after both channels are held
    chk_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready) |=> (!s_axi_bvalid ##1 s_axi_bvalid))
        else $error("write response not two cycles after both channels");

    chk_good_write: assert property ((wr_fire && (q.awaddr == OFF_WORD_A
        || q.awaddr == OFF_WORD_B)) |=> (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
        else $error("mapped write not answered OKAY");

    chk_bad_write: assert property ((wr_fire && q.awaddr != OFF_WORD_A
        && q.awaddr != OFF_WORD_B) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR
        && $stable(src_level)))
        else $error("unmapped write changed a field or answered OKAY");

    chk_read_answer: assert property ((s_axi_arvalid && s_axi_arready
        && (s_axi_araddr == OFF_WORD_A || s_axi_araddr == OFF_WORD_B))
        |=> (s_axi_rvalid && s_axi_rresp == RESP_OKAY))
        else $error("mapped read not answered OKAY next cycle");

    chk_bad_read: assert property ((s_axi_arvalid && s_axi_arready
        && s_axi_araddr != OFF_WORD_A && s_axi_araddr != OFF_WORD_B)
        |=> (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not answered SLVERR with zero data");

    // Field placement on writes: word A low byte lane alone, word B with both lanes
    chk_twi_write: assert property ((wr_fire && q.awaddr == OFF_WORD_A
        && q.wstrb[0]) |=> (src_level[SRC_TWI_C_MASTER] == $past(q.wdata[6:4])
        && src_level[SRC_TWI_C_SLAVE] == $past(q.wdata[2:0])))
        else $error("write to word A low byte not applied");

    chk_twi_kept: assert property ((wr_fire && q.awaddr == OFF_WORD_A
        && !q.wstrb[0]) |=> (src_level[SRC_TWI_C_MASTER] == $past(src_level[SRC_TWI_C_MASTER])
        && src_level[SRC_TWI_C_SLAVE] == $past(src_level[SRC_TWI_C_SLAVE])))
        else $error("word A low byte changed without its strobe");

    chk_word_b_write: assert property ((wr_fire && q.awaddr == OFF_WORD_B
        && q.wstrb == 2'h3) |=> (src_level[SRC_SERIAL_C_EVENT] == $past(q.wdata[14:12])
        && src_level[SRC_SERIAL_C_FAULT] == $past(q.wdata[10:8])
        && src_level[SRC_UART_D_TRANSMIT] == $past(q.wdata[6:4])
        && src_level[SRC_UART_D_RECEIVE] == $past(q.wdata[2:0])))
        else $error("write to word B not applied");

    cov_write_a: cover property (wr_fire && q.awaddr == OFF_WORD_A);
    cov_write_b: cover property (wr_fire && q.awaddr == OFF_WORD_B);
    cov_disabled_req: cover property (src_req[0] && src_level[0] == PRIO_OFF);
    cov_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cov_upper_strobe: cover property (wr_fire && q.awaddr == OFF_WORD_A && q.wstrb == 2'h2);

endmodule : ipb_bank

// *** hdl/ipb_pkg.sv ***
// Constants, field layout and state types for the interrupt priority field bank
package ipb_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 16;
    localparam logic [ADDR_W-1:0] OFF_WORD_A = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_WORD_B = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Priority encoding
    localparam int unsigned PRIO_W = 3;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_MIN = 3'h1;
    localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h7;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;

    // Sources, in field order
    localparam int unsigned NUM_SRC = 7;
    localparam int unsigned SRC_UART_D_ERROR = 0;
    localparam int unsigned SRC_TWI_C_MASTER = 1;
    localparam int unsigned SRC_TWI_C_SLAVE = 2;
    localparam int unsigned SRC_SERIAL_C_EVENT = 3;
    localparam int unsigned SRC_SERIAL_C_FAULT = 4;
    localparam int unsigned SRC_UART_D_TRANSMIT = 5;
    localparam int unsigned SRC_UART_D_RECEIVE = 6;

    // Lowest bit of each field within its word, and which word holds it
    localparam int unsigned SRC_POS [NUM_SRC] = '{12, 4, 0, 12, 8, 4, 0};
    localparam logic [NUM_SRC-1:0] SRC_IN_WORD_B = 7'h78;

    // Implemented bits of each word; all others read zero
    localparam logic [WORD_W-1:0] MASK_WORD_A = 16'h7077;
    localparam logic [WORD_W-1:0] MASK_WORD_B = 16'h7777;

    typedef logic [PRIO_W-1:0] ipb_prio_t;

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [WORD_W-1:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } ipb_axi_s;

    localparam ipb_axi_s AXI_RESET = '{
        aw_held: 1'b0, awaddr: 4'h0, w_held: 1'b0, wdata: 16'h0, wstrb: 2'h0,
        bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h0, rresp: 2'h0
    };

    typedef struct packed {
        ipb_prio_t prio;
        logic active;
    } ipb_cell_s;

    localparam ipb_cell_s CELL_RESET = '{prio: PRIO_RESET, active: 1'b0};

endpackage : ipb_pkg

// *** hdl/ipb_prio_cell.sv ***
// One three-bit priority field with its source gate
`timescale 1ns/1ps
module ipb_prio_cell
    import ipb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Field write
    input wire logic wr_en,
    input wire ipb_prio_t wr_data,
    // Source side
    input wire logic src_req,
    output ipb_prio_t level,
    output logic active
);

    ipb_cell_s q;
    ipb_cell_s d;

    always_comb begin
        d = q;
        if (wr_en) begin
            d.prio = wr_data;
        end
        // A zero field masks the source whatever its flag and enable say
        d.active = src_req && (q.prio != PRIO_OFF);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= CELL_RESET;
        end else begin
            q <= d;
        end
    end

    assign level = q.prio;
    assign active = q.active;

    chk_reset_level: assert property (@(posedge aclk) !aresetn |=> q.prio == PRIO_RESET)
        else $error("priority field not at level 4 after reset");

    chk_zero_disables: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.prio == PRIO_OFF) |=> !q.active)
        else $error("disabled source still requests");

    chk_top_level_req: assert property (@(posedge aclk) disable iff (!aresetn)
        (src_req && q.prio == PRIO_MAX && !wr_en) |=> (q.active && q.prio == PRIO_MAX))
        else $error("level 7 source did not request at level 7");

    chk_field_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en |=> (q.prio == $past(wr_data)) ##1 (q.active == ($past(src_req) && q.prio != PRIO_OFF)
        || $past(wr_en)))
        else $error("field write not stored or gate wrong");

endmodule : ipb_prio_cell

// *** sim/ipb_bank_tb.sv ***
// Self-checking bench for the interrupt priority field bank
`timescale 1ns/1ps
module ipb_bank_tb
    import ipb_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [NUM_SRC-1:0] src_req, src_active;
    ipb_prio_t [NUM_SRC-1:0] src_level;
    logic [31:0] val;
    int fails = 0;
    int comparisons = 0;

    ipb_bank i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .src_req(src_req), .src_level(src_level),
        .src_active(src_active));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic test_done();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Address and data offered together; each released once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                // One idle edge, so a following call never re-drives bready in this step
                @(posedge aclk);
                return;
            end
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        fails++;
        test_done();
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        logic ar_done;
        ar_done = 1'b0;
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid === 1'b1) begin
                val = rdata;
                resp = rresp;
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
            if (!ar_done && arready === 1'b1) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
        fails++;
        test_done();
    endtask : axi_rd

    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        src_req = 7'h7f;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(OFF_WORD_A);
        chk("reset word a", 32'h4044, val);
        chk("reset src_active", 32'h7f, {25'h0, src_active});
        axi_rd(OFF_WORD_B);
        chk("reset word b", 32'h4444, val);
        axi_wr(OFF_WORD_A, 32'hffffffff, 4'hf);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        axi_rd(OFF_WORD_A);
        chk("word a ones", 32'h7077, val);
        chk("uart error level", 32'h7, {29'h0, src_level[0]});
        // Upper byte strobe only: twi fields in the low byte must survive
        axi_wr(OFF_WORD_A, 32'h0, 4'h2);
        axi_rd(OFF_WORD_A);
        chk("word a strobe", 32'h0077, val);
        axi_wr(OFF_WORD_A, 32'h0, 4'hf);
        repeat (2) @(posedge aclk);
        chk("word a active", 32'h0, {29'h0, src_active[2:0]});
        for (int c = 0; c < 8; c++) begin
            axi_wr(OFF_WORD_B, 32'h1111 * c, 4'h3);
            repeat (2) @(posedge aclk);
            axi_rd(OFF_WORD_B);
            chk("word b code", 32'h1111 * c, val);
            chk("fault level", c, {29'h0, src_level[4]});
            chk("transmit level", c, {29'h0, src_level[5]});
            chk("word b active", (c != 0) ? 32'hf : 32'h0, {28'h0, src_active[6:3]});
        end
        src_req <= 7'h00;
        repeat (2) @(posedge aclk);
        chk("idle active", 32'h0, {25'h0, src_active});
        axi_wr(4'h8, 32'hffffffff, 4'hf);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_rd(4'hc);
        chk("unmapped read", 32'h0, val);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_rd(OFF_WORD_B);
        chk("word b kept", 32'h7777, val);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end
endmodule : ipb_bank_tb
